//--- afc_control.sv
`timescale 1ns/100ps
module afc_control #(
  parameter int MS_CYCLES = afc_pkg::MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // datapath status, same clock
  input  wire logic        fsref_tick,
  input  wire logic        headset_input_selected,
  input  wire logic        auto_gain_mute,
  input  wire logic [6:0]  auto_gain_level,
  // decoded configuration
  output logic             record_highpass_enable,
  output logic      [7:0]  record_highpass_corner,
  output logic      [5:0]  sample_word_bits,
  output logic             frame_i2s,
  output logic             frame_dsp,
  output logic             frame_right,
  output logic             frame_left,
  // sample rate enables, one-cycle pulses
  output logic             playback_sample_tick,
  output logic             record_sample_tick,
  // headset/aux gain stage and loop settings
  output logic             headset_pga_mute,
  output logic      [6:0]  headset_pga_gain,
  output logic             headset_auto_gain_active,
  output logic      [5:0]  headset_target_half_db,
  output logic             headset_attack_step,
  output logic             headset_decay_step
);

  // ==========================================================
  // register storage
  logic [15:0] audio_format_rate_control_reg;
  logic [15:0] headset_input_gain_control_reg;

  // fields of the format register
  logic [1:0] record_highpass_select;
  logic [1:0] sample_word_length;
  logic [1:0] serial_frame_format;
  logic [2:0] playback_rate_divisor;
  logic [2:0] record_rate_divisor;

  // fields of the headset gain register
  logic       headset_input_mute;
  logic [6:0] headset_input_gain;
  logic [2:0] headset_auto_gain_target;
  logic [3:0] headset_auto_gain_timing;
  logic       headset_auto_gain_enable;

  // derived controls
  logic       agc_live;
  logic [3:0] play_div_half;
  logic [3:0] rec_div_half;

  // format register field slices
  assign record_highpass_select =
    audio_format_rate_control_reg[afc_pkg::HPF_LSB +: 2];
  assign sample_word_length =
    audio_format_rate_control_reg[afc_pkg::SAMPLE_WORD_LENGTH_LSB +: 2];
  assign serial_frame_format =
    audio_format_rate_control_reg[afc_pkg::FRAME_LSB +: 2];
  assign playback_rate_divisor =
    audio_format_rate_control_reg[afc_pkg::PLAY_FS_LSB +: 3];
  assign record_rate_divisor =
    audio_format_rate_control_reg[afc_pkg::REC_FS_LSB +: 3];

  // headset gain register field slices
  assign headset_input_mute =
    headset_input_gain_control_reg[afc_pkg::MUTE_BIT];
  assign headset_input_gain =
    headset_input_gain_control_reg[afc_pkg::GAIN_LSB +: 7];
  assign headset_auto_gain_target =
    headset_input_gain_control_reg[afc_pkg::TARGET_LSB +: 3];
  assign headset_auto_gain_timing =
    headset_input_gain_control_reg[afc_pkg::TIMING_LSB +: 4];
  assign headset_auto_gain_enable =
    headset_input_gain_control_reg[afc_pkg::AGC_EN_BIT];

  // loop owns the gain only while enabled and on this input
  assign agc_live = headset_auto_gain_enable & headset_input_selected;

  // ==========================================================
  // write decode; a strobe to an unmapped offset hits nothing
  // and is dropped without side effects
  logic fmt_wr_hit;
  logic gain_wr_hit;

  assign fmt_wr_hit  = reg_wr && (reg_addr == afc_pkg::AUDIO_FMT_OFFSET);
  assign gain_wr_hit = reg_wr && (reg_addr == afc_pkg::HEADSET_GAIN_OFFSET);

  // format register write; reserved bits are masked so that
  // they can never hold a one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      audio_format_rate_control_reg <= afc_pkg::AUDIO_FMT_RESET; // R2
    end else if (fmt_wr_hit) begin
      audio_format_rate_control_reg <=
        reg_wdata & afc_pkg::AUDIO_FMT_WMASK; // R15
    end
  end

  // headset gain register write; starts muted at top gain code
  // writes are stored even while the loop owns the stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      headset_input_gain_control_reg <= afc_pkg::HEADSET_GAIN_RESET; // R8
    end else if (gain_wr_hit) begin
      headset_input_gain_control_reg <= reg_wdata; // R9
    end
  end

  // ==========================================================
  // read select: the addressed word, or zero for an unmapped
  // offset so software never sees a neighbour's contents
  logic [15:0] read_mux;

  always_comb begin
    read_mux = 16'h0000;
    if (reg_addr == afc_pkg::AUDIO_FMT_OFFSET) begin
      read_mux = audio_format_rate_control_reg; // R15
    end else if (reg_addr == afc_pkg::HEADSET_GAIN_OFFSET) begin
      if (agc_live) begin
        // the loop's live gain stands in for the stored bits
        read_mux = {auto_gain_mute, auto_gain_level,
                    headset_input_gain_control_reg[7:0]}; // R10
      end else begin
        read_mux = headset_input_gain_control_reg;
      end
    end
  end

  // read data stand one cycle after the strobe only and fall
  // back to zero, so a late sample cannot catch an old word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // highpass and word length decode, registered
  // registered so the datapath sees one settled code per edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      record_highpass_enable <= 1'b0;
      record_highpass_corner <= 8'h00;
      sample_word_bits       <= afc_pkg::WORD_BITS_RESET;
    end else begin
      record_highpass_enable <= (record_highpass_select != 2'h0); // R1
      record_highpass_corner <=
        afc_pkg::HPF_CORNER_TABLE[{record_highpass_select, 3'h0} +: 8]; // R1
      sample_word_bits <= 6'(afc_pkg::WORD_BITS_TABLE[
        {sample_word_length, 3'h0} +: 8]); // R2
    end
  end

  // serial frame format, one-hot to the serial port
  // exactly one of the four is high at any time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_i2s   <= 1'b1;
      frame_dsp   <= 1'b0;
      frame_right <= 1'b0;
      frame_left  <= 1'b0;
    end else begin
      frame_i2s   <= (serial_frame_format == afc_pkg::FRAME_I2S); // R3
      frame_dsp   <= (serial_frame_format == afc_pkg::FRAME_DSP); // R3
      // ratio check is software's job; the port just obeys
      frame_right <= (serial_frame_format == afc_pkg::FRAME_RIGHT); // R4
      frame_left  <= (serial_frame_format == afc_pkg::FRAME_LEFT); // R3
    end
  end

  // ==========================================================
  // sample rate enables from the reference tick; the reference
  // itself must already lie in its legal band
  // both dividers share the reference tick and the divisor
  // table, so codes kept equal since reset give ticks on the same edges
  assign play_div_half =
    afc_pkg::DIV_HALF_TABLE[{playback_rate_divisor, 2'h0} +: 4];
  assign rec_div_half =
    afc_pkg::DIV_HALF_TABLE[{record_rate_divisor, 2'h0} +: 4];

  // playback rate enable
  afc_rate_div u_play_div ( // R5
    .clk        (clk),
    .sys_rst    (sys_rst),
    .fsref_tick (fsref_tick), // R7
    .div_half   (play_div_half),
    .rate_tick  (playback_sample_tick)
  );

  // record rate enable; own accumulator, same divisor table
  afc_rate_div u_rec_div ( // R6
    .clk        (clk),
    .sys_rst    (sys_rst),
    .fsref_tick (fsref_tick),
    .div_half   (rec_div_half),
    .rate_tick  (record_sample_tick)
  );

  // ==========================================================
  // gain stage source: loop or software fields
  // mute and gain switch together, so the stage never pairs
  // a loop gain with a software mute
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      headset_pga_mute         <= 1'b1;
      headset_pga_gain         <= afc_pkg::PGA_GAIN_RESET;
      headset_auto_gain_active <= 1'b0;
    end else begin
      headset_auto_gain_active <= agc_live; // R14
      if (agc_live) begin
        headset_pga_mute <= auto_gain_mute; // R14
        headset_pga_gain <= auto_gain_level;
      end else begin
        headset_pga_mute <= headset_input_mute; // R8
        headset_pga_gain <= headset_input_gain; // R9
      end
    end
  end

  // target level decode
  // kept as a positive magnitude; the sign is always negative
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      headset_target_half_db <= afc_pkg::TARGET_RESET;
    end else begin
      headset_target_half_db <= 6'(afc_pkg::TARGET_TABLE[
        {headset_auto_gain_target, 3'h0} +: 8]); // R11
    end
  end

  // ==========================================================
  // loop step timing: a millisecond tick made from clk, so the
  // attack and decay periods do not follow the sample rate
  // MS_CYCLES is one millisecond of clk; benches shrink it
  localparam int MS_W = $clog2(MS_CYCLES + 1);

  logic [MS_W-1:0] ms_cnt_reg;
  logic            ms_tick;
  logic [8:0]      step_len [2];
  logic [1:0]      step_pulse;

  // counter restarts while the loop is off, so the first step
  // after enable comes a full period later
  always_ff @(posedge clk) begin
    if (sys_rst || !agc_live) begin
      ms_cnt_reg <= '0;
      ms_tick    <= 1'b0;
    end else if (ms_cnt_reg == MS_W'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= '0;
      ms_tick    <= 1'b1; // R13
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
      ms_tick    <= 1'b0;
    end
  end

  // low two timing bits pick attack, high two pick decay
  assign step_len[0] = 9'(afc_pkg::ATTACK_MS_TABLE[
    {headset_auto_gain_timing[1:0], 3'h0} +: 8]); // R12
  assign step_len[1] = afc_pkg::DECAY_MS_TABLE[
    {headset_auto_gain_timing[3:2], 4'h0} +: 9]; // R12

  // one step counter each for attack (0) and decay (1)
  for (genvar gi = 0; gi < 2; gi++) begin : g_step
    // millisecond ticks since the last step
    logic [8:0] step_cnt_reg;

    always_ff @(posedge clk) begin
      if (sys_rst || !agc_live) begin
        step_cnt_reg   <= 9'h000;
        step_pulse[gi] <= 1'b0;
      end else if (ms_tick) begin
        // a shortened period applies at once; a count already past it wraps at the next ms_tick
        if (step_cnt_reg >= step_len[gi] - 9'h001) begin
          step_cnt_reg   <= 9'h000;
          step_pulse[gi] <= 1'b1; // R13
        end else begin
          step_cnt_reg   <= step_cnt_reg + 9'h001;
          step_pulse[gi] <= 1'b0;
        end
      end else begin
        step_pulse[gi] <= 1'b0;
      end
    end
  end

  // named outputs; each bit is a flop inside the loop
  assign headset_attack_step = step_pulse[0];
  assign headset_decay_step  = step_pulse[1];

endmodule // afc_control

//--- afc_pkg.sv
// Operation
// R1 - highpass code: off, or three corner fractions
// R2 - word length 16/20/24/32, resets to 16
// R3 - frame: I2S, DSP, right, left justified
// R4 - right justified needs integer rate ratio
// R5 - playback rate is reference over eight divisors
// R6 - record rate uses same divisor set
// R7 - reference rate kept within 39-53 kHz
// R8 - mute bit one mutes, resets muted
// R9 - gain in half-dB steps, resets all ones
// R10 - under auto gain, readback shows live gain
// R11 - target code picks eight output levels
// R12 - timing field picks attack and decay times
// R13 - loop timing independent of sample rate
// R14 - enable hands gain stage to auto loop
// R15 - reserved bits read zero, ignore writes
package afc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0]  AUDIO_FMT_OFFSET   = 8'h00;
  localparam logic [7:0]  HEADSET_GAIN_OFFSET = 8'h01;
  localparam logic [15:0] AUDIO_FMT_RESET    = 16'h0000;
  localparam logic [15:0] HEADSET_GAIN_RESET = 16'hff00;
  // decoded outputs after reset: 16-bit words, top gain, -5.5 dB
  localparam logic [5:0]  WORD_BITS_RESET    = 6'h10;
  localparam logic [6:0]  PGA_GAIN_RESET     = 7'h7f;
  localparam logic [5:0]  TARGET_RESET       = 6'h0b;
  // writable bits of the format register; the rest read zero
  localparam logic [15:0] AUDIO_FMT_WMASK    = 16'hcf3f;

  // ==========================================================
  // field positions, format register
  localparam int HPF_LSB     = 14;
  localparam int SAMPLE_WORD_LENGTH_LSB    = 10;
  localparam int FRAME_LSB   = 8;
  localparam int PLAY_FS_LSB = 3;
  localparam int REC_FS_LSB  = 0;

  // field positions, headset gain register
  localparam int MUTE_BIT    = 15;
  localparam int GAIN_LSB    = 8;
  localparam int TARGET_LSB  = 5;
  localparam int TIMING_LSB  = 1;
  localparam int AGC_EN_BIT  = 0;

  // ==========================================================
  // frame format codes
  localparam logic [1:0] FRAME_I2S   = 2'h0;
  localparam logic [1:0] FRAME_DSP   = 2'h1;
  localparam logic [1:0] FRAME_RIGHT = 2'h2;
  localparam logic [1:0] FRAME_LEFT  = 2'h3;

  // ==========================================================
  // decode tables, entry 0 in the low bits
  // rate divisor times two: 1,1.5,2,3,4,5,5.5,6
  localparam logic [31:0] DIV_HALF_TABLE = 32'hcba8_6432;
  // highpass corner in units of 0.0001 of sample rate
  localparam logic [31:0] HPF_CORNER_TABLE = 32'hfa7d_2d00;
  // bits per sample
  localparam logic [31:0] WORD_BITS_TABLE = 32'h2018_1410;
  // target level magnitude in half-dB
  localparam logic [63:0] TARGET_TABLE = 64'h3028_221c_1814_100b;
  // attack time in ms
  localparam logic [31:0] ATTACK_MS_TABLE = 32'h1410_0b08;
  // decay time in ms
  localparam logic [63:0] DECAY_MS_TABLE = 64'h01f4_0190_00c8_0064;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_TICK_PS    = 1000000000;
  localparam int MS_CYCLES     = MS_TICK_PS / CLK_PERIOD_PS;

endpackage

//--- afc_rate_div.sv
`timescale 1ns/100ps
// fractional divider: emits one tick per div_half/2 reference ticks,
// which covers the 1.5 and 5.5 divisors without a faster clock
module afc_rate_div (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       fsref_tick,
  input  wire logic [3:0] div_half,
  output logic            rate_tick
);

  logic [4:0] acc_reg;
  logic [4:0] acc_sum;

  // each reference tick adds two half-units
  assign acc_sum = acc_reg + 5'h02;

  // ==========================================================
  // accumulator; a shrinking divisor can leave acc above it,
  // the compare then fires at once and the residue settles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_reg   <= 5'h00;
      rate_tick <= 1'b0;
    end else if (fsref_tick) begin
      if (acc_sum >= {1'b0, div_half}) begin
        acc_reg   <= acc_sum - {1'b0, div_half};
        rate_tick <= 1'b1;
      end else begin
        acc_reg   <= acc_sum;
        rate_tick <= 1'b0;
      end
    end else begin
      rate_tick <= 1'b0;
    end
  end

endmodule // afc_rate_div

//--- afc_control_properties.sv
`timescale 1ns/100ps
// ==========================================================
// port checker for the format and headset gain registers
module afc_control_checker #(
  parameter int MS_CYCLES = 10
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        fsref_tick,
  input wire logic        auto_gain_mute,
  input wire logic [6:0]  auto_gain_level,
  input wire logic        record_highpass_enable,
  input wire logic [7:0]  record_highpass_corner,
  input wire logic [5:0]  sample_word_bits,
  input wire logic        frame_i2s,
  input wire logic        frame_dsp,
  input wire logic        frame_right,
  input wire logic        frame_left,
  input wire logic        playback_sample_tick,
  input wire logic        record_sample_tick,
  input wire logic        headset_pga_mute,
  input wire logic [6:0]  headset_pga_gain,
  input wire logic        headset_auto_gain_active,
  input wire logic        headset_attack_step,
  input wire logic        headset_decay_step
);
  localparam logic [7:0] CORNER [4] = '{8'h00, 8'h2d, 8'h7d, 8'hfa};
  localparam logic [5:0] WBITS [4]  = '{6'h10, 6'h14, 6'h18, 6'h20};
  logic [1:0]  fmt_wr;
  logic [15:0] wd1;
  logic [15:0] wd2;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ========================================================
  // write pipeline: decoded outputs settle two edges later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fmt_wr <= 2'h0;
    end else begin
      fmt_wr <= {fmt_wr[0], reg_wr && reg_addr == 8'h00};
    end
  end

  // write data delayed to line up with the decode
  always_ff @(posedge clk) begin
    wd1 <= reg_wdata;
    wd2 <= wd1;
  end

  // ========================================================
  // properties
  AST_HPF_DECODE: assert property (fmt_wr[1] |->
    record_highpass_corner == CORNER[wd2[15:14]] &&
    record_highpass_enable == (wd2[15:14] != 2'h0))
    else $error("highpass decode wrong");
  AST_SAMPLE_WORD_LENGTH_DECODE: assert property (fmt_wr[1] |->
    sample_word_bits == WBITS[wd2[11:10]])
    else $error("word length decode wrong");
  AST_FRAME_DECODE: assert property (fmt_wr[1] |->
    {frame_left, frame_right, frame_dsp, frame_i2s} == 4'h1 << wd2[9:8])
    else $error("frame format decode wrong");
  AST_RSVD_ZERO: assert property ($past(reg_rd) &&
    $past(reg_addr) == 8'h00 |-> (reg_rdata & 16'h30c0) == 16'h0000)
    else $error("reserved bits read nonzero");
  AST_MUTE_RESET: assert property ($past(sys_rst) |->
    headset_pga_mute && headset_pga_gain == 7'h7f)
    else $error("gain stage not muted after reset");
  AST_PLAY_TICK: assert property (playback_sample_tick |->
    $past(fsref_tick))
    else $error("playback tick without reference tick");
  AST_REC_TICK: assert property (record_sample_tick |->
    $past(fsref_tick))
    else $error("record tick without reference tick");
  AST_PGA_FOLLOW: assert property (headset_auto_gain_active |->
    {headset_pga_mute, headset_pga_gain} ==
    $past({auto_gain_mute, auto_gain_level}))
    else $error("gain stage not following the loop");
  AST_LIVE_READ: assert property ($past(reg_rd) &&
    $past(reg_addr) == 8'h01 && headset_auto_gain_active |->
    reg_rdata[15:8] == $past({auto_gain_mute, auto_gain_level}))
    else $error("readback not showing live gain");
  AST_ATTACK_GAP: assert property (headset_attack_step |=>
    !headset_attack_step [*8])
    else $error("attack steps too close");
  AST_STEP_LIVE: assert property (headset_attack_step ||
    headset_decay_step |->
    headset_auto_gain_active || $past(headset_auto_gain_active))
    else $error("loop step while loop is off");
endmodule // afc_control_checker

bind afc_control afc_control_checker #(.MS_CYCLES(MS_CYCLES))
  afc_control_checker_inst (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fsref_tick(fsref_tick),
  .auto_gain_mute(auto_gain_mute), .auto_gain_level(auto_gain_level),
  .record_highpass_enable(record_highpass_enable),
  .record_highpass_corner(record_highpass_corner),
  .sample_word_bits(sample_word_bits), .frame_i2s(frame_i2s),
  .frame_dsp(frame_dsp), .frame_right(frame_right),
  .frame_left(frame_left), .playback_sample_tick(playback_sample_tick),
  .record_sample_tick(record_sample_tick),
  .headset_pga_mute(headset_pga_mute),
  .headset_pga_gain(headset_pga_gain),
  .headset_auto_gain_active(headset_auto_gain_active),
  .headset_attack_step(headset_attack_step),
  .headset_decay_step(headset_decay_step));

//--- tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// register bank testbench
module tb_top;
  localparam int MSC = 10;
  localparam int DIV2 [8] = '{2, 3, 4, 6, 8, 10, 11, 12};
  localparam int CRN [4]  = '{0, 45, 125, 250};
  localparam int WB [4]   = '{16, 20, 24, 32};
  localparam int TG [8]   = '{11, 16, 20, 24, 28, 34, 40, 48};
  localparam int AT [4]   = '{8, 11, 16, 20};
  localparam int DC [4]   = '{100, 200, 400, 500};
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic fsref_tick = 1'b0, sel = 1'b1, ag_mute = 1'b1;
  logic [6:0] ag_level = 7'h15, pga_gain;
  logic hp_en, i2s, dsp, rj, lj, pt, rt, pga_mute, act, atk, dcy;
  logic [7:0] hp_c;
  logic [5:0] wbits, tgt;
  int fail_count = 0, total_checks = 0, pcnt = 0, rcnt = 0, n;

  afc_control #(.MS_CYCLES(MSC)) afc_control_inst (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fsref_tick(fsref_tick), .headset_input_selected(sel),
    .auto_gain_mute(ag_mute), .auto_gain_level(ag_level),
    .record_highpass_enable(hp_en), .record_highpass_corner(hp_c),
    .sample_word_bits(wbits), .frame_i2s(i2s), .frame_dsp(dsp),
    .frame_right(rj), .frame_left(lj), .playback_sample_tick(pt),
    .record_sample_tick(rt), .headset_pga_mute(pga_mute),
    .headset_pga_gain(pga_gain), .headset_auto_gain_active(act),
    .headset_target_half_db(tgt), .headset_attack_step(atk),
    .headset_decay_step(dcy));

  // 200 MHz clock
  always #2.5 clk = ~clk;
  // sample tick counters, cleared while reset is high; the only
  // driver of both, so a reset cannot race an increment
  always @(posedge clk) begin
    if (sys_rst) begin
      pcnt <= 0;
      rcnt <= 0;
    end else begin
      pcnt <= pcnt + int'(pt);
      rcnt <= rcnt + int'(rt);
    end
  end

  // ========================================================
  // tasks
  task results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task rst;
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data lands at the strobe's sampling edge
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  // cycles between two consecutive loop steps, bounded
  task gap(input logic w, output int c);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1 i++;
    end while (!(w ? dcy : atk) && i < 12000);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (!(w ? dcy : atk) && c < 12000);
    if (i >= 12000 || c >= 12000) begin
      fail_count++;
      results();
    end
  endtask

  // ========================================================
  // main sequence
  initial begin
    rst();
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'hff00);
    check({8'h00, pga_mute, pga_gain}, 16'h00ff);
    check(16'(wbits), 16'd16);
    check(16'(act), 16'd0);
    // every code of the highpass, word length and frame fields, reserved bits set
    for (int k = 0; k < 4; k++) begin
      d = 16'(k << 14 | k << 10 | k << 8 | k << 3 | k) | 16'h30c0;
      wr(8'h00, d);
      @(posedge clk);
      #1 check(16'(hp_c), 16'(CRN[k]));
      check(16'(hp_en), 16'(k != 0));
      check(16'(wbits), 16'(WB[k]));
      check(16'({lj, rj, dsp, i2s}), 16'(1 << k));
      rd(8'h00, d & 16'hcf3f);
    end
    wr(8'h05, 16'hffff);
    rd(8'h05, 16'h0000);
    rd(8'h00, d & 16'hcf3f);
    // rate divisors: 660 reference ticks divide evenly by all
    for (int c = 0; c < 8; c++) begin
      rst();
      wr(8'h00, 16'(c << 3 | c));
      @(posedge clk);
      for (int j = 0; j < 660; j++) begin
        @(posedge clk) fsref_tick <= 1'b1;
        @(posedge clk) fsref_tick <= 1'b0;
      end
      repeat (3) @(posedge clk);
      check(16'(pcnt), 16'(1320 / DIV2[c]));
      check(16'(rcnt), 16'(1320 / DIV2[c]));
    end
    // target codes with the loop off
    for (int k = 0; k < 8; k++) begin
      wr(8'h01, 16'h2a00 | 16'(k << 5));
      @(posedge clk);
      #1 check(16'(tgt), 16'(TG[k]));
      check({8'h00, pga_mute, pga_gain}, 16'h002a);
    end
    // loop on: gain stage and readback follow the loop
    for (int k = 0; k < 4; k++) begin
      d = 16'h2a01 | 16'(k << 5) | 16'(k * 5 << 1);
      @(posedge clk) ag_level <= 7'(7'h15 + k);
      // a new sample rate each pass: loop timing must not follow it
      wr(8'h00, 16'(k << 3 | k));
      wr(8'h01, d);
      repeat (2) @(posedge clk);
      #1 check({8'h00, pga_mute, pga_gain}, 16'h0095 + 16'(k));
      check(16'(act), 16'd1);
      rd(8'h01, {8'h95 + 8'(k), d[7:0]});
      gap(1'b0, n);
      check(16'(n), 16'(AT[k] * MSC));
      gap(1'b1, n);
      check(16'(n), 16'(DC[k] * MSC));
    end
    @(posedge clk) sel <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check({8'h00, pga_mute, pga_gain}, 16'h002a);
    check(16'(act), 16'd0);
    rd(8'h01, d);
    results();
  end
endmodule // tb_top
